// >>> verilog/sbtc_pkg.sv
/*
  Package for the sixteen-bit timer/counter: register offsets, reset
  values, field positions, divider counts and the control-word layout.
  Assumes a 32-bit Avalon-MM register bus with byte addresses, where
  each register takes one aligned word with its data in bits 7:0.
*/
`default_nettype none

package sbtc_pkg;

  // register byte offsets on the bus
  localparam int unsigned SBTC_AW = 5;
  localparam logic [4:0] SBTC_OFF_LOW = 5'h00;
  localparam logic [4:0] SBTC_OFF_HIGH = 5'h04;
  localparam logic [4:0] SBTC_OFF_CTRL = 5'h08;
  localparam logic [4:0] SBTC_OFF_FLAGS = 5'h0C;
  localparam logic [4:0] SBTC_OFF_FLAG_CLR = 5'h10;
  localparam logic [4:0] SBTC_OFF_ENABLES = 5'h14;
  localparam logic [4:0] SBTC_OFF_PRIORITY = 5'h18;

  // reset values and implemented-bit masks
  localparam logic [7:0] SBTC_CTRL_RST = 8'h00;
  localparam logic [7:0] SBTC_CTRL_IMPL = 8'hB7;
  localparam logic [7:0] SBTC_FLAGS_RST = 8'h00;
  localparam logic [7:0] SBTC_ENABLES_RST = 8'h00;
  localparam logic [7:0] SBTC_PRIO_RST = 8'h1F;
  localparam logic [7:0] SBTC_PRIO_IMPL = 8'h1F;
  localparam logic [15:0] SBTC_CNT_RST = 16'h0000;
  localparam logic [15:0] SBTC_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] SBTC_HBUF_RST = 8'h00;
  localparam logic [2:0] SBTC_PRESC_RST = 3'h0;

  // overflow flag, enable and priority bit position
  localparam int unsigned SBTC_OVF_BIT = 1;

  // instruction clock is the system clock divided by four
  localparam int unsigned SBTC_INSTR_DIV = 4;
  localparam logic [1:0] SBTC_DIV_LAST = 2'(SBTC_INSTR_DIV - 1);
  localparam logic [1:0] SBTC_DIV_RST = 2'h0;
  localparam logic [2:0] SBTC_SYNC_RST = 3'h0;

  // control register layout
  typedef struct packed {
    logic wide_access_select;
    logic rsv6;
    logic [1:0] prescale_select;
    logic rsv3;
    logic external_sync_disable;
    logic clock_source_select;
    logic counter_run;
  } sbtc_ctrl_s;

endpackage : sbtc_pkg

`default_nettype wire

// >>> verilog/sbtc_timer.sv
/*
  Sixteen-bit timer/counter with prescaler, buffered 16-bit access,
  overflow flag with enable and priority, and an Avalon-MM slave.
  Assumes one 50 MHz system clock taken as the oscillator, an external
  count clock arriving on a pin, and a bus master that holds its
  request until waitrequest falls.
*/
`timescale 1ns/10ps
`default_nettype none

module sbtc_timer
  import sbtc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [SBTC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic shared_external_count_clock_i,
  output logic irq_o,
  output logic irq_priority_o
);

  // address match, used by both the read and the write decode
  function automatic logic hit(input logic [SBTC_AW-1:0] a, input logic [SBTC_AW-1:0] off);
    hit = (a[SBTC_AW-1:2] == off[SBTC_AW-1:2]);
  endfunction : hit

  sbtc_ctrl_s ctrl_r;
  logic [15:0] cnt_r;
  logic [7:0] hbuf_r;
  logic [2:0] presc_r;
  logic [1:0] div_r;
  logic [2:0] sync_r;
  logic lvl_r;
  logic fell_seen_r;
  logic [7:0] flags_r;
  logic [7:0] enables_r;
  logic [7:0] prio_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // bus handshake: one wait cycle, then the request is accepted
  wire req = avs_read_i | avs_write_i;
  wire rd_first = avs_read_i & ~ack_r;
  wire wr_acc = avs_write_i & ack_r & avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o = rdata_r;

  // write strobes per register, and the read strobe for the low byte only
  wire wr_low = wr_acc & hit(avs_address_i, SBTC_OFF_LOW);
  wire wr_high = wr_acc & hit(avs_address_i, SBTC_OFF_HIGH);
  wire wr_ctrl = wr_acc & hit(avs_address_i, SBTC_OFF_CTRL);
  wire wr_clr = wr_acc & hit(avs_address_i, SBTC_OFF_FLAG_CLR);
  wire wr_en = wr_acc & hit(avs_address_i, SBTC_OFF_ENABLES);
  wire wr_prio = wr_acc & hit(avs_address_i, SBTC_OFF_PRIORITY);
  wire rd_low = rd_first & hit(avs_address_i, SBTC_OFF_LOW);

  // read mux; unmapped and write-only addresses read as zero
  wire [7:0] rd_byte =
    hit(avs_address_i, SBTC_OFF_LOW) ? cnt_r[7:0] :
    hit(avs_address_i, SBTC_OFF_HIGH) ?
      (ctrl_r.wide_access_select ? hbuf_r : cnt_r[15:8]) :
    hit(avs_address_i, SBTC_OFF_CTRL) ? (ctrl_r & SBTC_CTRL_IMPL) :
    hit(avs_address_i, SBTC_OFF_FLAGS) ? flags_r :
    hit(avs_address_i, SBTC_OFF_ENABLES) ? enables_r :
    hit(avs_address_i, SBTC_OFF_PRIORITY) ? prio_r : 8'h00;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (rd_first) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // instruction clock divider, the Fosc/4 enable
  wire instr_tick = (div_r == SBTC_DIV_LAST);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= SBTC_DIV_RST;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // pin synchronizer; the filtered level moves only when stages 2 and 3 agree
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_r <= SBTC_SYNC_RST;
      lvl_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], shared_external_count_clock_i};
      if (sync_r[1] == sync_r[2]) begin
        lvl_r <= sync_r[2];
      end
    end
  end

  // synchronized path edges on the filtered level; the raw path skips
  // the filter, one cycle sooner but glitch-prone
  wire sync_rise = (sync_r[1] == sync_r[2]) & sync_r[2] & ~lvl_r;
  wire sync_fall = (sync_r[1] == sync_r[2]) & ~sync_r[2] & lvl_r;
  wire raw_rise = sync_r[1] & ~sync_r[2];
  wire raw_fall = ~sync_r[1] & sync_r[2];
  wire ext_rise = ctrl_r.external_sync_disable ? raw_rise : sync_rise;
  wire ext_fall = ctrl_r.external_sync_disable ? raw_fall : sync_fall;

  // a rising edge counts only once a falling edge was seen
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fell_seen_r <= 1'b0;
    end else if (!ctrl_r.counter_run || !ctrl_r.clock_source_select) begin
      fell_seen_r <= 1'b0;
    end else if (ext_fall) begin
      fell_seen_r <= 1'b1;
    end
  end

  // mode select: timer, synchronous or asynchronous counter
  wire src_tick = ctrl_r.clock_source_select ? (ext_rise & fell_seen_r)
                                             : instr_tick;
  wire in_tick = ctrl_r.counter_run & src_tick;

  // prescaler passes one tick in 1, 2, 4 or 8
  wire [2:0] presc_mask = 3'((4'h1 << ctrl_r.prescale_select) - 4'h1);
  wire cnt_inc = in_tick & ((presc_r & presc_mask) == presc_mask);
  wire wrap = cnt_inc & (cnt_r == SBTC_CNT_MAX);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r <= SBTC_PRESC_RST;
    end else if (wr_low) begin
      presc_r <= SBTC_PRESC_RST;
    end else if (in_tick) begin
      presc_r <= presc_r + 3'h1;
    end
  end

  // counter and high-byte buffer; a software write wins over a count
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= SBTC_CNT_RST;
      hbuf_r <= SBTC_HBUF_RST;
    end else begin
      if (wr_low && ctrl_r.wide_access_select) begin
        cnt_r <= {hbuf_r, wd};
      end else if (wr_low) begin
        cnt_r[7:0] <= wd;
      end else if (wr_high && !ctrl_r.wide_access_select) begin
        cnt_r[15:8] <= wd;
      end else if (cnt_inc) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (wr_high && ctrl_r.wide_access_select) begin
        hbuf_r <= wd;
      end else if (rd_low && ctrl_r.wide_access_select) begin
        hbuf_r <= cnt_r[15:8];
      end
    end
  end

  // control, enable and priority registers; unimplemented bits stay zero
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= SBTC_CTRL_RST;
      enables_r <= SBTC_ENABLES_RST;
      prio_r <= SBTC_PRIO_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wd & SBTC_CTRL_IMPL;
      end
      if (wr_en) begin
        enables_r <= wd & (8'h01 << SBTC_OVF_BIT);
      end
      if (wr_prio) begin
        prio_r <= wd & SBTC_PRIO_IMPL;
      end
    end
  end

  // sticky overflow flag; a wrap in the clearing cycle wins
  wire [7:0] flag_set = {7'h00, wrap} << SBTC_OVF_BIT;
  wire [7:0] flag_clr = wr_clr ? wd : 8'h00;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_r <= SBTC_FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // level interrupt while an enabled flag is set
  assign irq_o = |(flags_r & enables_r);
  assign irq_priority_o = prio_r[SBTC_OVF_BIT];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_high_read_buf: assert property (
    rd_first && hit(avs_address_i, SBTC_OFF_HIGH) && ctrl_r.wide_access_select
    |=> avs_readdata_o[7:0] == $past(hbuf_r))
    else $error("wide high read did not return the buffer");

  a_low_read_snap: assert property (
    rd_low && ctrl_r.wide_access_select && !wr_high
    |=> hbuf_r == $past(cnt_r[15:8]))
    else $error("low read did not snapshot the high byte");

  a_high_write_buf: assert property (
    wr_high && ctrl_r.wide_access_select
    |=> hbuf_r == $past(wd))
    else $error("wide high write missed the buffer");

  a_low_write_load: assert property (
    wr_low && ctrl_r.wide_access_select
    |=> cnt_r == {$past(hbuf_r), $past(wd)} && presc_r == 3'h0)
    else $error("wide low write did not load both bytes");

  a_presc_keep: assert property (
    wr_high && !in_tick |=> presc_r == $past(presc_r))
    else $error("high write disturbed the prescaler");

  a_wrap_flag: assert property (
    wrap && !wr_low && !wr_high
    |=> cnt_r == 16'h0000 && flags_r[SBTC_OVF_BIT])
    else $error("wrap did not clear count and set flag");

  a_flag_sticky: assert property (
    flags_r[SBTC_OVF_BIT] && !(wr_clr && wd[SBTC_OVF_BIT])
    |=> flags_r[SBTC_OVF_BIT])
    else $error("overflow flag dropped without a clear");

  a_irq_gate: assert property (
    !enables_r[SBTC_OVF_BIT] |-> !irq_o)
    else $error("interrupt raised while disabled");

  a_stop_hold: assert property (
    !ctrl_r.counter_run && !wr_low && !wr_high |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");

  a_internal_rate: assert property (
    !ctrl_r.clock_source_select && cnt_inc |-> instr_tick)
    else $error("internal source counted off the instruction tick");

  a_first_fall: assert property (
    ctrl_r.clock_source_select && !fell_seen_r |-> !cnt_inc)
    else $error("external edge counted before a falling edge");

  a_prescale_8: assert property (
    cnt_inc && ctrl_r.prescale_select == 2'h3 |-> presc_r == 3'h7)
    else $error("1:8 prescale passed a tick early");

  // byte path, timer rate, sync path, falling-edge arming and interrupt level
  a_narrow_high_write: assert property (
    wr_high && !ctrl_r.wide_access_select
    |=> cnt_r[15:8] == $past(wd))
    else $error("narrow high write did not reach the count");

  a_timer_tick: assert property (
    ctrl_r.counter_run && !ctrl_r.clock_source_select && instr_tick
    && ctrl_r.prescale_select == 2'h0 |-> cnt_inc)
    else $error("timer missed an instruction tick");

  a_sync_path: assert property (
    ctrl_r.clock_source_select && !ctrl_r.external_sync_disable && cnt_inc |-> sync_rise)
    else $error("synchronized counter advanced without a filtered rise");

  a_fall_arm: assert property (
    ctrl_r.counter_run && ctrl_r.clock_source_select && ext_fall |=> fell_seen_r)
    else $error("falling edge did not arm the counter");

  a_irq_level: assert property (
    flags_r[SBTC_OVF_BIT] && enables_r[SBTC_OVF_BIT] |-> irq_o)
    else $error("enabled overflow did not raise the interrupt");

endmodule : sbtc_timer

`default_nettype wire

// >>> dv/sbtc_ext_src.sv
/*
  Model of the external count clock source on the shared pin.
  Assumes the bench calls burst from a process timed by clk_sys_i.
*/
`timescale 1ns/10ps
`default_nettype none
module sbtc_ext_src (
  input wire logic clk_sys_i,
  output logic pin_o
);
  // idles low between bursts, so the first rise of a burst is not counted
  initial pin_o = 1'b0;

  // each level lasts half clocks; two or more keeps the filter happy
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge clk_sys_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge clk_sys_i);
      pin_o <= 1'b0;
    end
  endtask : burst
endmodule : sbtc_ext_src
`default_nettype wire

// >>> dv/sbtc_timer_tb.sv
/*
  Self-checking bench for the timer/counter.
  Assumes the edge source model; the bus task waits for waitrequest low.
*/
`timescale 1ns/10ps
`default_nettype none
module sbtc_timer_tb
  import sbtc_pkg::*;
;
  logic clk_sys_i, arst_n_i, rd, wr, ext, irq, prio, wreq;
  logic [SBTC_AW-1:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  int mismatches, checked;

  sbtc_timer u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .shared_external_count_clock_i(ext), .irq_o(irq), .irq_priority_o(prio));
  sbtc_ext_src u_src (.clk_sys_i(clk_sys_i), .pin_o(ext));

  // free-running 50 MHz clock, never the count source, so the sync bit stays usable
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // one request, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic wt;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    // waitrequest and read data are both taken at the accepting edge
    do begin
      @(posedge clk_sys_i);
      wt = wreq;
      q = rdat[7:0];
    end while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr8

  task automatic rc(input string n, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask : rc

  task automatic t_reset();
    rc("control", SBTC_OFF_CTRL, 8'h00);
    rc("flags", SBTC_OFF_FLAGS, 8'h00);
    rc("enables", SBTC_OFF_ENABLES, 8'h00);
    rc("priority", SBTC_OFF_PRIORITY, 8'h1F);
    rc("unmapped", 5'h1C, 8'h00);
    chk("irq_priority_o", 8'h01, {7'h00, prio});
    wr8(SBTC_OFF_PRIORITY, 8'h00);
    rc("priority write", SBTC_OFF_PRIORITY, 8'h00);
    chk("irq_priority_o low", 8'h00, {7'h00, prio});
    // a write without byte lane 0 must leave the register alone
    @(posedge clk_sys_i);
    be <= 4'hE;
    wr8(SBTC_OFF_ENABLES, 8'h02);
    be <= 4'hF;
    rc("lane 0 off", SBTC_OFF_ENABLES, 8'h00);
    wr8(SBTC_OFF_CTRL, 8'hB7);
    rc("control mask", SBTC_OFF_CTRL, 8'hB7);
  endtask : t_reset

  // byte access, then buffered wide access
  task automatic t_bytes();
    wr8(SBTC_OFF_CTRL, 8'h00);
    wr8(SBTC_OFF_LOW, 8'h34);
    wr8(SBTC_OFF_HIGH, 8'h12);
    rc("low", SBTC_OFF_LOW, 8'h34);
    rc("high", SBTC_OFF_HIGH, 8'h12);
    wr8(SBTC_OFF_CTRL, 8'h80);
    wr8(SBTC_OFF_HIGH, 8'hAB);
    wr8(SBTC_OFF_CTRL, 8'h00);
    rc("live high", SBTC_OFF_HIGH, 8'h12);
    wr8(SBTC_OFF_CTRL, 8'h80);
    wr8(SBTC_OFF_LOW, 8'hCD);
    wr8(SBTC_OFF_CTRL, 8'h00);
    rc("loaded high", SBTC_OFF_HIGH, 8'hAB);
    wr8(SBTC_OFF_HIGH, 8'h66);
    wr8(SBTC_OFF_CTRL, 8'h80);
    rc("wide low", SBTC_OFF_LOW, 8'hCD);
    rc("wide high", SBTC_OFF_HIGH, 8'h66);
  endtask : t_bytes

  // tick phase is free-running, so one count either way is allowed
  task automatic t_presc();
    int e;
    logic [7:0] v;
    for (int ps = 0; ps < 4; ps++) begin
      wr8(SBTC_OFF_CTRL, 8'h00);
      wr8(SBTC_OFF_HIGH, 8'h00);
      wr8(SBTC_OFF_LOW, 8'h00);
      wr8(SBTC_OFF_CTRL, {2'b00, 2'(ps), 4'h5});
      repeat (256) @(posedge clk_sys_i);
      wr8(SBTC_OFF_CTRL, 8'h00);
      bus(1'b0, SBTC_OFF_LOW, 8'h00, v);
      e = 64 >> ps;
      chk("prescaled count", ((v >= 8'(e - 1)) && (v <= 8'(e + 1))) === 1'b1 ? v : 8'(e), v);
      repeat (40) @(posedge clk_sys_i);
      rc("stopped count", SBTC_OFF_LOW, v);
    end
  endtask : t_presc

  // five rises from idle low: the first has no falling edge before it
  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      wr8(SBTC_OFF_CTRL, 8'h00);
      wr8(SBTC_OFF_LOW, 8'h00);
      wr8(SBTC_OFF_CTRL, {5'h00, 1'(s), 2'b11});
      u_src.burst(5, 4);
      repeat (8) @(posedge clk_sys_i);
      wr8(SBTC_OFF_CTRL, 8'h00);
      rc("edge count", SBTC_OFF_LOW, 8'h04);
    end
  endtask : t_ext

  task automatic t_ovf();
    wr8(SBTC_OFF_HIGH, 8'hFF);
    wr8(SBTC_OFF_LOW, 8'hFE);
    wr8(SBTC_OFF_CTRL, 8'h01);
    repeat (20) @(posedge clk_sys_i);
    wr8(SBTC_OFF_CTRL, 8'h00);
    rc("overflow flag", SBTC_OFF_FLAGS, 8'h02);
    @(negedge clk_sys_i);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr8(SBTC_OFF_ENABLES, 8'h02);
    @(negedge clk_sys_i);
    chk("irq enabled", 8'h01, {7'h00, irq});
    rc("sticky flag", SBTC_OFF_FLAGS, 8'h02);
    wr8(SBTC_OFF_FLAG_CLR, 8'h02);
    @(negedge clk_sys_i);
    chk("irq cleared", 8'h00, {7'h00, irq});
    wr8(SBTC_OFF_FLAGS, 8'hFF);
    rc("read-only flags", SBTC_OFF_FLAGS, 8'h00);
  endtask : t_ovf

  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // the whole run needs well under 20000 cycles
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {rd, wr, adr, wdat} = '0;
    be = 4'hF;
    arst_n_i = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_bytes();
    t_presc();
    t_ext();
    t_ovf();
    print_verdict();
  end
endmodule : sbtc_timer_tb
`default_nettype wire
